// File: pkg/odc_pkg.sv
package odc_pkg;

   // Frame layout
   localparam int FRAME_BITS = 16;
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 12;
   localparam int CODE_MSB = 11;
   localparam int CODE_LSB = 2;
   localparam int CH_MSB = 14;
   localparam int CH_LSB = 12;
   localparam int NUM_CH = 8;
   localparam int CODE_W = 10;
   localparam int CNT_W = 6;

   // Edge counts within a frame
   localparam logic [5:0] EDGE_LOW_LAST = 6'h0E;
   localparam logic [5:0] EDGE_MARK = 6'h0F;
   localparam logic [5:0] EDGE_MIN_EXEC = 6'h0F;
   localparam logic [5:0] EDGE_SAT = 6'h3F;

   // Command nibble codes
   localparam logic [3:0] CMD_MODE_REG = 4'h8;
   localparam logic [3:0] CMD_MODE_IMM = 4'h9;
   localparam logic [3:0] CMD_UPD_SEL = 4'hA;
   localparam logic [3:0] CMD_CHA_WR = 4'hB;
   localparam logic [3:0] CMD_BCAST = 4'hC;
   localparam logic [3:0] CMD_PD_HIZ = 4'hD;
   localparam logic [3:0] CMD_PD_100K = 4'hE;
   localparam logic [3:0] CMD_PD_2K5 = 4'hF;

   // Output termination: TERM_ON while active, the rest while powered down
   localparam logic [1:0] TERM_ON = 2'h0;
   localparam logic [1:0] TERM_HIZ = 2'h1;
   localparam logic [1:0] TERM_100K = 2'h2;
   localparam logic [1:0] TERM_2K5 = 2'h3;

   // APB register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_LAST_CMD = 8'h08;
   localparam logic [7:0] ADDR_FRAMES = 8'h0C;
   localparam logic [7:0] ADDR_CH_BASE = 8'h20;
   localparam logic [7:0] ADDR_CH_LAST = 8'h3C;

   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int STAT_MODE_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_PD_LSB = 8;
   localparam int CHR_OUT_LSB = 16;
   localparam int CHR_TERM_LSB = 28;

   // Reset values
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   typedef enum logic [0:0] {
      ODC_MODE_REG = 1'b0,
      ODC_MODE_IMM = 1'b1
   } odc_mode_t;

   typedef enum logic [0:0] {
      ODC_FR_IDLE = 1'b0,
      ODC_FR_SHIFT = 1'b1
   } odc_frame_t;

   // Synchronised link pins
   typedef struct packed {
      logic sclk;
      logic sel_n;
      logic din;
   } odc_link_t;

   // Whole state of the decoder
   typedef struct packed {
      odc_frame_t fr;
      odc_mode_t mode;
      logic [CNT_W-1:0] cnt;
      logic [FRAME_BITS-1:0] sr;
      logic sclk_d;
      logic sel_n_d;
      logic dout;
      logic [NUM_CH-1:0][CODE_W-1:0] data;
      logic [NUM_CH-1:0][CODE_W-1:0] out;
      logic [NUM_CH-1:0] pd;
      logic [NUM_CH-1:0][1:0] term;
      logic en;
      logic [FRAME_BITS-1:0] last_cmd;
      logic [15:0] frames;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } odc_state_t;

endpackage : odc_pkg

// File: rtl/odc_sync.sv
`timescale 1ns/100ps

// Two-stage synchroniser for pins from outside the pclk domain
module odc_sync #(
   parameter int WIDTH = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } odc_sync_state_t;

   odc_sync_state_t st_ff;
   odc_sync_state_t nxt_st;

   // First stage feeds only the second stage
   always_comb
   begin
      nxt_st.meta = async_in;
      nxt_st.stable = st_ff.meta;
   end

   // Both stages reset to zero, then follow the pins two cycles late
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.stable;

endmodule : odc_sync

// File: rtl/odc_decoder.sv
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps

module odc_decoder (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_shift_clock,
   input wire logic frame_select_n,
   input wire logic serial_in,
   output logic serial_through_out,
   output logic [odc_pkg::NUM_CH-1:0][odc_pkg::CODE_W-1:0] chan_out,
   output logic [odc_pkg::NUM_CH-1:0] chan_pd,
   output logic [odc_pkg::NUM_CH-1:0][1:0] chan_term,
   output logic update_mode
);

   odc_pkg::odc_state_t st_ff;
   odc_pkg::odc_state_t nxt_st;
   odc_pkg::odc_link_t link_async;
   odc_pkg::odc_link_t link;

   // Link pins cross into pclk through two flops each
   assign link_async = '{sclk: serial_shift_clock, sel_n: frame_select_n, din: serial_in};

   odc_sync #(
      .WIDTH(3)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(link_async),
      .sync_out(link)
   );

   // Edge detection on the synchronised pins only
   logic sclk_fall;
   logic sel_fall;
   logic sel_rise;
   logic [odc_pkg::CNT_W-1:0] cnt_next;
   logic [3:0] cmd;
   logic [odc_pkg::CODE_W-1:0] code;
   logic [2:0] chan_idx;
   logic [7:0] mask;
   logic exec_ok;
   logic apb_access;
   logic apb_done;
   logic [2:0] reg_ch;
   logic reg_is_ch;

   assign sclk_fall = st_ff.sclk_d & ~link.sclk;
   assign sel_fall = st_ff.sel_n_d & ~link.sel_n;
   assign sel_rise = ~st_ff.sel_n_d & link.sel_n;
   assign cnt_next = (st_ff.cnt == odc_pkg::EDGE_SAT) ? st_ff.cnt : st_ff.cnt + 6'h01;

   // Fields of the held frame
   assign cmd = st_ff.sr[odc_pkg::CMD_MSB:odc_pkg::CMD_LSB];
   assign code = st_ff.sr[odc_pkg::CODE_MSB:odc_pkg::CODE_LSB];
   assign chan_idx = st_ff.sr[odc_pkg::CH_MSB:odc_pkg::CH_LSB];
   assign mask = st_ff.sr[7:0];
   // A frame that saw fewer than fifteen falling edges is dropped
   assign exec_ok = st_ff.en && (st_ff.fr == odc_pkg::ODC_FR_SHIFT) &&
                    (st_ff.cnt >= odc_pkg::EDGE_MIN_EXEC);

   // APB: access phase lasts two cycles, pready rises in the second
   assign apb_access = psel & penable;
   assign apb_done = apb_access & st_ff.pready;
   assign reg_is_ch = (paddr >= odc_pkg::ADDR_CH_BASE) && (paddr <= odc_pkg::ADDR_CH_LAST) &&
                      (paddr[1:0] == 2'h0);
   assign reg_ch = paddr[4:2];

   // Next-state logic for link, channels and register bus
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.sclk_d = link.sclk;
      nxt_st.sel_n_d = link.sel_n;

      // Frame sequencing
      case (st_ff.fr)
         odc_pkg::ODC_FR_IDLE:
         begin
            if (sel_fall)
            begin
               nxt_st.fr = odc_pkg::ODC_FR_SHIFT;
               nxt_st.cnt = '0;
               nxt_st.sr = '0;
               nxt_st.dout = 1'b0;
            end
         end
         odc_pkg::ODC_FR_SHIFT:
         begin
            if (sel_rise)
            begin
               nxt_st.fr = odc_pkg::ODC_FR_IDLE;
               nxt_st.cnt = '0;
               nxt_st.dout = 1'b0;
            end
            else if (sclk_fall)
            begin
               nxt_st.sr = {st_ff.sr[odc_pkg::FRAME_BITS-2:0], link.din};
               nxt_st.cnt = cnt_next;
               // Through path lags the input by fifteen edges
               if (cnt_next <= odc_pkg::EDGE_LOW_LAST)
               begin
                  nxt_st.dout = 1'b0;
               end
               else if (cnt_next == odc_pkg::EDGE_MARK)
               begin
                  nxt_st.dout = 1'b1;
               end
               else
               begin
                  nxt_st.dout = st_ff.sr[odc_pkg::FRAME_BITS-2];
               end
            end
         end
         default:
         begin
            nxt_st.fr = odc_pkg::ODC_FR_IDLE;
         end
      endcase

      // Execute on the frame-select rising edge so a whole chain acts at once
      if (sel_rise && exec_ok)
      begin
         nxt_st.last_cmd = st_ff.sr;
         nxt_st.frames = st_ff.frames + 16'h0001;
         if (!st_ff.sr[odc_pkg::CMD_MSB])
         begin
            nxt_st.data[chan_idx] = code;
            if (st_ff.mode == odc_pkg::ODC_MODE_IMM)
            begin
               nxt_st.out[chan_idx] = code;
               nxt_st.pd[chan_idx] = 1'b0;
               nxt_st.term[chan_idx] = odc_pkg::TERM_ON;
            end
         end
         else
         begin
            // Special commands other than the two mode commands leave the mode untouched
            case (cmd)
               odc_pkg::CMD_MODE_REG:
               begin
                  nxt_st.mode = odc_pkg::ODC_MODE_REG;
               end
               odc_pkg::CMD_MODE_IMM:
               begin
                  nxt_st.mode = odc_pkg::ODC_MODE_IMM;
               end
               odc_pkg::CMD_UPD_SEL:
               begin
                  for (int i = 0; i < odc_pkg::NUM_CH; i++)
                  begin
                     if (mask[i])
                     begin
                        nxt_st.out[i] = st_ff.data[i];
                        nxt_st.pd[i] = 1'b0;
                        nxt_st.term[i] = odc_pkg::TERM_ON;
                     end
                  end
               end
               odc_pkg::CMD_CHA_WR:
               begin
                  for (int i = 1; i < odc_pkg::NUM_CH; i++)
                  begin
                     nxt_st.out[i] = st_ff.data[i];
                  end
                  nxt_st.data[0] = code;
                  nxt_st.out[0] = code;
                  nxt_st.pd = '0;
                  nxt_st.term = '0;
               end
               odc_pkg::CMD_BCAST:
               begin
                  for (int i = 0; i < odc_pkg::NUM_CH; i++)
                  begin
                     nxt_st.data[i] = code;
                     nxt_st.out[i] = code;
                  end
                  nxt_st.pd = '0;
                  nxt_st.term = '0;
               end
               odc_pkg::CMD_PD_HIZ, odc_pkg::CMD_PD_100K, odc_pkg::CMD_PD_2K5:
               begin
                  // Data registers survive power-down untouched
                  for (int i = 0; i < odc_pkg::NUM_CH; i++)
                  begin
                     if (mask[i])
                     begin
                        nxt_st.pd[i] = 1'b1;
                        nxt_st.term[i] = cmd[1:0];
                     end
                  end
               end
               default:
               begin
                  nxt_st.mode = st_ff.mode;
               end
            endcase
         end
      end

      // Register bus: pready one cycle into the access phase
      nxt_st.pready = apb_access & ~st_ff.pready;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = odc_pkg::RDATA_ZERO;
      if (apb_access && !st_ff.pready)
      begin
         if (paddr == odc_pkg::ADDR_CTRL)
         begin
            nxt_st.prdata[odc_pkg::CTRL_EN_BIT] = st_ff.en;
         end
         else if (paddr == odc_pkg::ADDR_STATUS)
         begin
            nxt_st.prdata[odc_pkg::STAT_MODE_BIT] = st_ff.mode;
            nxt_st.prdata[odc_pkg::STAT_BUSY_BIT] = st_ff.fr;
            nxt_st.prdata[odc_pkg::STAT_PD_LSB +: odc_pkg::NUM_CH] = st_ff.pd;
         end
         else if (paddr == odc_pkg::ADDR_LAST_CMD)
         begin
            nxt_st.prdata[odc_pkg::FRAME_BITS-1:0] = st_ff.last_cmd;
         end
         else if (paddr == odc_pkg::ADDR_FRAMES)
         begin
            nxt_st.prdata[15:0] = st_ff.frames;
         end
         else if (reg_is_ch)
         begin
            nxt_st.prdata[odc_pkg::CODE_W-1:0] = st_ff.data[reg_ch];
            nxt_st.prdata[odc_pkg::CHR_OUT_LSB +: odc_pkg::CODE_W] = st_ff.out[reg_ch];
            nxt_st.prdata[odc_pkg::CHR_TERM_LSB +: 2] = st_ff.term[reg_ch];
         end
         else
         begin
            nxt_st.pslverr = 1'b1; // Unmapped address
         end
         // Only the control register is writable
         if (pwrite && (paddr != odc_pkg::ADDR_CTRL))
         begin
            nxt_st.pslverr = 1'b1;
         end
      end

      // Writes land on the completing edge only
      if (apb_done && pwrite && (paddr == odc_pkg::ADDR_CTRL))
      begin
         nxt_st.en = pwdata[odc_pkg::CTRL_EN_BIT];
      end
   end

   // Reset clears channels to zero and selects register-only mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff.fr <= odc_pkg::ODC_FR_IDLE;
         st_ff.mode <= odc_pkg::ODC_MODE_REG;
         st_ff.cnt <= '0;
         st_ff.sr <= '0;
         st_ff.sclk_d <= 1'b0;
         st_ff.sel_n_d <= 1'b0; // Matches synchroniser reset, so release is no frame start
         st_ff.dout <= 1'b0;
         st_ff.data <= '0;
         st_ff.out <= '0;
         st_ff.pd <= '0;
         st_ff.term <= '0;
         st_ff.en <= odc_pkg::CTRL_EN_RST;
         st_ff.last_cmd <= '0;
         st_ff.frames <= '0;
         st_ff.pready <= 1'b0;
         st_ff.pslverr <= 1'b0;
         st_ff.prdata <= odc_pkg::RDATA_ZERO;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // All outputs straight from state flops
   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign serial_through_out = st_ff.dout;
   assign chan_out = st_ff.out;
   assign chan_pd = st_ff.pd;
   assign chan_term = st_ff.term;
   assign update_mode = st_ff.mode;

endmodule : odc_decoder

// File: verification/odc_chk_sva.sv
`timescale 1ns/100ps

// Port-level checks of the decoder, all in the pclk domain
module odc_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_select_n,
   input wire logic serial_through_out,
   input wire logic [odc_pkg::NUM_CH-1:0][odc_pkg::CODE_W-1:0] chan_out,
   input wire logic [odc_pkg::NUM_CH-1:0] chan_pd,
   input wire logic update_mode
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // First access cycle, then a one-cycle answer
   sequence acc_s;
      psel && $rose(penable);
   endsequence
   sequence ans_s;
      pready ##1 !pready;
   endsequence
   // Frame select idle long enough to pass the synchroniser
   sequence idle_s;
      frame_select_n [*6];
   endsequence

   apb_wait_a: assert property (acc_s |=> ans_s)
      else $error("answer not one wait state");
   wr_refuse_a: assert property (pready && pwrite && paddr != odc_pkg::ADDR_CTRL |-> pslverr)
      else $error("write to read-only accepted");
   unmapped_a: assert property (pready && paddr == 8'h10 |-> pslverr && ~|prdata)
      else $error("unmapped read not refused");
   rd_idle_a: assert property (!pready |-> ~|prdata && !pslverr)
      else $error("read bus not quiet");
   rst_zero_a: assert property ($rose(presetn) |-> ~|chan_out && !update_mode && ~|chan_pd)
      else $error("outputs not clear after reset");
   out_cause_a: assert property (!$stable(chan_out) |-> $past(frame_select_n, 2))
      else $error("output changed inside frame");
   mode_cause_a: assert property (!$stable(update_mode) |-> $past(frame_select_n, 2))
      else $error("mode changed inside frame");
   pd_cause_a: assert property (!$stable(chan_pd) |-> $past(frame_select_n, 2))
      else $error("power-down changed inside frame");
   thru_idle_a: assert property (idle_s |-> !serial_through_out)
      else $error("through output high between frames");
endmodule : odc_chk

bind odc_decoder odc_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .frame_select_n(frame_select_n),
   .serial_through_out(serial_through_out), .chan_out(chan_out), .chan_pd(chan_pd),
   .update_mode(update_mode));

// File: verification/odc_host.sv
`timescale 1ns/100ps

// Host serial controller; link clock idles high between frames
module odc_host (
   output logic sclk,
   output logic sel_n,
   output logic din,
   input wire logic dout
);
   logic [31:0] so;

   initial
   begin
      sclk = 1'b1;
      sel_n = 1'b1;
      din = 1'b0;
      so = 32'h0;
   end

   // Shift n bits MSB first from the top of w, 160 ns per bit
   task automatic frame(input logic [31:0] w, input int n);
      sel_n = 1'b0;
      #80;
      for (int k = 0; k < n; k++)
      begin
         din = w[31-k];
         #80 sclk = 1'b0;
         #80 so[31-k] = dout; // Captured late so the through bit has settled
         sclk = 1'b1;
      end
      #40 sel_n = 1'b1;
      din = ~din; // Released line does not keep its value
      #400;
   endtask : frame
endmodule : odc_host

// File: verification/test_octal_dac_serial_command_decoder.sv
`timescale 1ns/100ps

// Self-checking bench for the decoder
module test_octal_dac_serial_command_decoder;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, sclk, sel_n, din, dout, umode, er;
   logic [7:0][9:0] c_out, m_out, m_data;
   logic [7:0][1:0] c_term, m_term;
   logic [7:0] c_pd, m_pd;
   logic m_mode;
   logic [15:0] cw [12] = '{16'h0FFC, 16'h1C00, 16'hA003, 16'h9000, 16'h6800, 16'hD0F0,
      16'hE00F, 16'hF300, 16'h5FFC, 16'hB3FF, 16'h8000, 16'hC800};
   int err_total = 0;
   int checks_done = 0;
   integer seed = 32'hE6EB;

   always #4 pclk = ~pclk;

   odc_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_shift_clock(sclk), .frame_select_n(sel_n),
      .serial_in(din), .serial_through_out(dout), .chan_out(c_out), .chan_pd(c_pd),
      .chan_term(c_term), .update_mode(umode));
   odc_host i_host (.sclk(sclk), .sel_n(sel_n), .din(din), .dout(dout));

   task automatic check(input string nm, input logic [99:0] seen, input logic [99:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      if (n >= 50)
         err_total++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Expected effect of one executed command
   function automatic void apply(input logic [15:0] w);
      logic [9:0] d;
      logic [7:0] u;
      d = w[11:2];
      u = 8'h00;
      if (!w[15])
      begin
         m_data[w[14:12]] = d;
         u[w[14:12]] = m_mode;
      end
      case (w[15:12])
         4'h8: m_mode = 1'b0;
         4'h9: m_mode = 1'b1;
         4'hA: u = w[7:0];
         4'hB:
         begin
            m_data[0] = d;
            u = 8'hFF;
         end
         4'hC:
         begin
            m_data = {8{d}};
            u = 8'hFF;
         end
         default:
            for (int i = 0; i < 8; i++)
               if (w[15] && w[i])
               begin
                  m_pd[i] = 1'b1;
                  m_term[i] = w[13:12];
               end
      endcase
      for (int i = 0; i < 8; i++)
         if (u[i])
         begin
            m_out[i] = m_data[i];
            m_pd[i] = 1'b0;
            m_term[i] = 2'h0;
         end
   endfunction : apply

   // Compare pins, status and one channel word with the model
   task automatic verify(input logic [2:0] ch);
      check("chan_out", c_out, m_out);
      check("pd_term", {c_pd, c_term}, {m_pd, m_term});
      check("mode", umode, m_mode);
      apb(1'b0, 8'h04, 32'h0);
      check("status", {rd[15:8], rd[0]}, {m_pd, m_mode});
      apb(1'b0, 8'h20 + 8'(ch) * 8'h04, 32'h0);
      check("chan_reg", {rd[29:28], rd[25:16], rd[9:0]},
         {m_term[ch], m_out[ch], m_data[ch]});
   endtask : verify

   // Send a frame, update the model when it counts, then compare
   task automatic send(input logic [31:0] w, input int n, input logic en);
      i_host.frame(w, n);
      if (en && n >= 16)
         apply(w[32-n +: 16]);
      repeat (12) @(posedge pclk);
      verify(w[30:28]);
   endtask : send

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // Main sequence: corners first, then random frames
   initial
   begin
      {m_out, m_data, m_term, m_pd, m_mode} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      verify(3'h7);
      apb(1'b0, odc_pkg::ADDR_CTRL, 32'h0);
      check("ctrl_rst", rd[0], 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped", {er, rd}, {1'b1, 32'h0});
      apb(1'b1, odc_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
      check("ro_write", er, 1'b1);
      foreach (cw[i])
         send({cw[i], 16'h0000}, 16, 1'b1);
      send({16'h0FFC, 16'h0000}, 14, 1'b1);
      send({16'h5A5C, 16'hC124}, 32, 1'b1);
      check("through", i_host.so[31:1], {14'h0000, 1'h1, 16'h5A5C});
      apb(1'b0, odc_pkg::ADDR_LAST_CMD, 32'h0);
      check("last_cmd", rd[15:0], 16'hC124);
      apb(1'b1, odc_pkg::ADDR_CTRL, 32'h0);
      send({16'hC000, 16'h0000}, 16, 1'b0);
      apb(1'b1, odc_pkg::ADDR_CTRL, 32'h1);
      repeat (40)
         send({16'($random(seed)), 16'h0000}, 16, 1'b1);
      finish_test();
   end

   // Watchdog well beyond the expected run time
   initial
   begin
      #500000;
      err_total++;
      finish_test();
   end
endmodule : test_octal_dac_serial_command_decoder
